// ==== swdw_params.svh ====
/*
 * Constants of the sleep, wake and watchdog block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef SWDW_PARAMS_SVH
`define SWDW_PARAMS_SVH

// =====================================================================
// Register byte offsets
`define SWDW_OFF_INTCTL 8'h00
`define SWDW_OFF_STATUS 8'h04
`define SWDW_OFF_OPTION 8'h08
`define SWDW_OFF_CONFIG 8'h0C
`define SWDW_OFF_WDTCNT 8'h10

// =====================================================================
// Field positions
`define SWDW_IC_GIE 7
`define SWDW_IC_INTF 1
`define SWDW_IC_IOCF 0
`define SWDW_ST_TO 4
`define SWDW_ST_PD 3
`define SWDW_OP_INTEDG 6
`define SWDW_OP_PSA 3
`define SWDW_OP_PS_MSB 2
`define SWDW_CF_MCLRE 5
`define SWDW_CF_WATCHDOG_ENABLE_CFG 3

// =====================================================================
// Reset values
`define SWDW_RST_INTCTL 8'h00
`define SWDW_RST_STATUS 8'h18
`define SWDW_RST_OPTION 8'hFF
`define SWDW_RST_CONFIG 14'h3FFF

// =====================================================================
// Timing
`define SWDW_CLK_PERIOD_NS 10
`define SWDW_WDT_PERIOD_NS 18000000
`define SWDW_WDT_CYCLES (`SWDW_WDT_PERIOD_NS / `SWDW_CLK_PERIOD_NS)

`endif

// ==== swdw_pkg.sv ====
/*
 * Types shared by the sleep, wake and watchdog block.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package swdw_pkg;
   // =================================================================
   // Power state of the core
   typedef enum logic [0:0] {
      SWDW_RUN,
      SWDW_SLEEP
   } swdw_state_t;

   typedef logic [1:0] swdw_resp_t;
   localparam swdw_resp_t SWDW_OKAY = 2'h0;
   localparam swdw_resp_t SWDW_SLVERR = 2'h2;
endpackage

// ==== swdw_top.sv ====
/*
 * Sleep entry, wake-up control and watchdog timer, with an AXI4-Lite
 * register slave for interrupt control, status, options and config.
 * Assumes the core gives one-cycle sleep and clear-watchdog strobes on
 * CLK_SYS, and that interrupt and reset pins are asynchronous.
 */
`timescale 1ns/1ps
`include "swdw_params.svh"

// What this block does
// - Power-down is entered only by executing the sleep instruction.
// - Sleep entry clears the watchdog; enabled watchdog keeps counting asleep.
// - Sleep entry clears power-down flag bit 3, sets time-out flag bit 4.
// - Asleep, CPU clock stops and I/O keep their prior drive states.
// - Sleep touches no other reset source nor stored analog enables.
// - Wake on reset pin, power-on, watchdog, external or change interrupt.
// - Wake-capable peripheral interrupts are change and external pin events.
// - The sleep instruction prefetches the next program address.
// - Only individually enabled interrupts wake, whatever global enable says.
// - After interrupt wake run next instruction, vector if globally enabled.
// - Every wake clears the watchdog counter.
// - Enabled flag pending before sleep makes sleep a no-operation.
// - Flag set during or after sleep: full sleep, then immediate wake.
// - Watchdog runs only when its configuration enable bit is set.
// - Timeout resets the device when running, wakes it when asleep.
// - Timeout nominally 18 ms, extended up to 1:128 by prescaler.
// - Clear-watchdog and sleep clear counter and assigned prescaler.
// - Watchdog timeout clears the time-out flag.
// - Prescaler assignment and ratio may change at any time.
module swdw_top #(
   parameter int WDT_CYCLES = `SWDW_WDT_CYCLES,
   parameter logic [13:0] CONFIG_WORD = `SWDW_RST_CONFIG,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Core strobes
   input wire logic SLEEP_OP,
   input wire logic CLEAR_WATCHDOG_OP,
   // Asynchronous pins
   input wire logic EXT_INT_PIN,
   input wire logic IOC_PIN,
   input wire logic EXTERNAL_RESET_PIN_N,
   // Core control
   output logic CPU_CLK_EN,
   output logic IO_HOLD,
   output logic PREFETCH_NEXT,
   output logic WAKE,
   output logic WAKE_VECTOR,
   output logic DEV_RESET,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output swdw_pkg::swdw_resp_t S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output swdw_pkg::swdw_resp_t S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   import swdw_pkg::*;

   // ==================================================================
   // Declarations
   swdw_state_t state_q;
   logic [7:0] intctl_q, intctl_d, status_q, status_d, option_q;
   logic [31:0] base_cnt_q;
   logic [6:0] post_cnt_q, ratio_last;
   logic [2:0] int_sync_q, ioc_sync_q, rst_sync_q;
   logic int_evt, ioc_evt, pin_reset, pend, watchdog_enable_cfg, prescaler_assign;
   logic sleep_take, sleep_nop, wake_now, wdt_to, base_wrap;
   logic wdt_clear, pre_clear, wr_fire, rd_fire, wr_ok;
   logic cpu_clk_en_q, io_hold_q, prefetch_q, wake_q, wake_vec_q;
   logic dev_reset_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   swdw_resp_t bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [7:0] wbyte;

   // ==================================================================
   // Pin synchronisers and edge detection
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         int_sync_q <= 3'h0;
         ioc_sync_q <= 3'h0;
         rst_sync_q <= 3'h7;
      end else begin
         int_sync_q <= {int_sync_q[1:0], EXT_INT_PIN};
         ioc_sync_q <= {ioc_sync_q[1:0], IOC_PIN};
         rst_sync_q <= {rst_sync_q[1:0], EXTERNAL_RESET_PIN_N};
      end
   end

   // Edge polarity of the external pin follows the option register
   assign int_evt = option_q[`SWDW_OP_INTEDG] ?
                    (int_sync_q[1] & ~int_sync_q[2]) :
                    (~int_sync_q[1] & int_sync_q[2]);
   assign ioc_evt = ioc_sync_q[1] ^ ioc_sync_q[2];
   // Pin reset only when enabled in config; unaffected by sleep
   assign pin_reset = CONFIG_WORD[`SWDW_CF_MCLRE] & ~rst_sync_q[1];

   // ==================================================================
   // Sleep control
   assign watchdog_enable_cfg = CONFIG_WORD[`SWDW_CF_WATCHDOG_ENABLE_CFG];
   assign prescaler_assign = option_q[`SWDW_OP_PSA];
   // Enable bits 5:3 pair with flag bits 2:0
   assign pend = |(intctl_q[5:3] & intctl_q[2:0]);
   assign sleep_take = SLEEP_OP & (state_q == SWDW_RUN) & ~pend;
   assign sleep_nop = SLEEP_OP & (state_q == SWDW_RUN) & pend;
   // Flags that rose during the sleep cycle wake on the next one
   assign wake_now = (state_q == SWDW_SLEEP) & (pend | wdt_to)
                     & ~pin_reset;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_q <= SWDW_RUN;
      end else begin
         case (state_q)
            SWDW_RUN: begin
               if (sleep_take && !pin_reset) begin
                  state_q <= SWDW_SLEEP;
               end
            end
            SWDW_SLEEP: begin
               if (wake_now || pin_reset) begin
                  state_q <= SWDW_RUN;
               end
            end
            default: begin
               state_q <= SWDW_RUN;
            end
         endcase
      end
   end

   // Core clock gate, I/O hold and wake strobes
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cpu_clk_en_q <= 1'b1;
         io_hold_q <= 1'b0;
         prefetch_q <= 1'b0;
         wake_q <= 1'b0;
         wake_vec_q <= 1'b0;
      end else begin
         if (sleep_take && !pin_reset) begin
            cpu_clk_en_q <= 1'b0;
            io_hold_q <= 1'b1;
         end else if (wake_now || pin_reset) begin
            cpu_clk_en_q <= 1'b1;
            io_hold_q <= 1'b0;
         end
         prefetch_q <= SLEEP_OP & (state_q == SWDW_RUN);
         wake_q <= wake_now;
         // Core runs the next instruction, then vectors if enabled
         wake_vec_q <= wake_now & pend & intctl_q[`SWDW_IC_GIE];
      end
   end

   // Device reset: pin reset, or watchdog timeout while running
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         dev_reset_q <= 1'b0;
      end else begin
         dev_reset_q <= pin_reset
                        | (wdt_to & (state_q == SWDW_RUN));
      end
   end

   // ==================================================================
   // Watchdog: free-running base period plus optional prescaler
   assign base_wrap = (base_cnt_q == 32'(WDT_CYCLES - 1));
   assign ratio_last = 7'((8'h01 << option_q[`SWDW_OP_PS_MSB:0]) - 8'h01);
   assign wdt_to = watchdog_enable_cfg & base_wrap
                   & (~prescaler_assign | (post_cnt_q >= ratio_last));
   assign wdt_clear = CLEAR_WATCHDOG_OP | sleep_take | wake_now | wdt_to
                      | pin_reset;
   assign pre_clear = wdt_clear & (prescaler_assign | wdt_to | wake_now);

   // Runs on CLK_SYS, which is never gated by sleep
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         base_cnt_q <= 32'h0;
      end else if (!watchdog_enable_cfg || wdt_clear) begin
         base_cnt_q <= 32'h0;
      end else if (base_wrap) begin
         base_cnt_q <= 32'h0;
      end else begin
         base_cnt_q <= base_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         post_cnt_q <= 7'h0;
      end else if (!watchdog_enable_cfg || pre_clear) begin
         post_cnt_q <= 7'h0;
      end else if (base_wrap && prescaler_assign) begin
         post_cnt_q <= post_cnt_q + 7'h1;
      end
   end

   // ==================================================================
   // AXI4-Lite slave: address and data taken together
   assign wr_fire = S_AXI_AWVALID & S_AXI_WVALID & ~awready_q & ~bvalid_q;
   assign rd_fire = S_AXI_ARVALID & ~arready_q & ~rvalid_q;
   assign wr_ok = S_AXI_WSTRB[0];
   assign wbyte = S_AXI_WDATA[7:0];

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= SWDW_OKAY;
      end else begin
         awready_q <= wr_fire;
         wready_q <= wr_fire;
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            case (S_AXI_AWADDR)
               `SWDW_OFF_INTCTL, `SWDW_OFF_STATUS, `SWDW_OFF_OPTION,
               `SWDW_OFF_CONFIG, `SWDW_OFF_WDTCNT: bresp_q <= SWDW_OKAY;
               default: bresp_q <= SWDW_SLVERR;
            endcase
         end else if (S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= SWDW_OKAY;
         rdata_q <= 32'h0;
      end else begin
         arready_q <= rd_fire;
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= SWDW_OKAY;
            case (S_AXI_ARADDR)
               `SWDW_OFF_INTCTL: rdata_q <= {24'h0, intctl_q};
               `SWDW_OFF_STATUS: rdata_q <= {24'h0, status_q};
               `SWDW_OFF_OPTION: rdata_q <= {24'h0, option_q};
               `SWDW_OFF_CONFIG: rdata_q <= {18'h0, CONFIG_WORD};
               `SWDW_OFF_WDTCNT: rdata_q <= base_cnt_q;
               default: begin
                  rdata_q <= 32'h0;
                  rresp_q <= SWDW_SLVERR;
               end
            endcase
         end else if (S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ==================================================================
   // Registers
   always_comb begin
      intctl_d = intctl_q;
      if (wr_fire && wr_ok && S_AXI_AWADDR == `SWDW_OFF_INTCTL) begin
         intctl_d = wbyte;
      end
      // Hardware set wins over a software clear
      intctl_d[`SWDW_IC_INTF] = intctl_d[`SWDW_IC_INTF] | int_evt;
      intctl_d[`SWDW_IC_IOCF] = intctl_d[`SWDW_IC_IOCF] | ioc_evt;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         intctl_q <= `SWDW_RST_INTCTL;
      end else begin
         intctl_q <= intctl_d;
      end
   end

   always_comb begin
      status_d = status_q;
      // Software owns all but the power-down and time-out flags
      if (wr_fire && wr_ok && S_AXI_AWADDR == `SWDW_OFF_STATUS) begin
         status_d[7:5] = wbyte[7:5];
         status_d[2:0] = wbyte[2:0];
      end
      if (CLEAR_WATCHDOG_OP) begin
         status_d[`SWDW_ST_TO] = 1'b1;
         status_d[`SWDW_ST_PD] = 1'b1;
      end
      if (sleep_take) begin
         status_d[`SWDW_ST_PD] = 1'b0;
         status_d[`SWDW_ST_TO] = 1'b1;
      end
      if (wdt_to) begin
         status_d[`SWDW_ST_TO] = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         status_q <= `SWDW_RST_STATUS;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         option_q <= `SWDW_RST_OPTION;
      end else if (wr_fire && wr_ok && S_AXI_AWADDR == `SWDW_OFF_OPTION) begin
         option_q <= wbyte;
      end
   end

   // ==================================================================
   // Outputs
   assign CPU_CLK_EN = cpu_clk_en_q;
   assign IO_HOLD = io_hold_q;
   assign PREFETCH_NEXT = prefetch_q;
   assign WAKE = wake_q;
   assign WAKE_VECTOR = wake_vec_q;
   assign DEV_RESET = dev_reset_q;
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RRESP = rresp_q;
   assign S_AXI_RDATA = rdata_q;

   // ==================================================================
   // Assertions
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   sleep_only_op_a: assert property (
      (state_q == SWDW_RUN) ##1 (state_q == SWDW_SLEEP)
      |-> $past(SLEEP_OP))
      else $error("sleep entered without sleep op");
   entry_clears_wdt_a: assert property (
      sleep_take && !pin_reset |=> base_cnt_q == 32'h0 ##1
      (!watchdog_enable_cfg || $past(wdt_clear) || base_cnt_q == 32'h1))
      else $error("watchdog not cleared or stalled on sleep");
   entry_flags_a: assert property (
      sleep_take && !wdt_to |=> !status_q[`SWDW_ST_PD]
      && status_q[`SWDW_ST_TO])
      else $error("status flags wrong after sleep entry");
   sleep_clock_a: assert property (
      state_q == SWDW_SLEEP |-> !CPU_CLK_EN && IO_HOLD)
      else $error("core clock running while asleep");
   sleep_nop_a: assert property (
      sleep_nop && !pin_reset && !wdt_to && !CLEAR_WATCHDOG_OP
      |=> state_q == SWDW_RUN
      && $stable(status_q[4:3]))
      else $error("pending sleep not treated as no-op");
   pend_wake_a: assert property (
      state_q == SWDW_SLEEP && pend && !pin_reset |=> WAKE
      && state_q == SWDW_RUN)
      else $error("pending interrupt did not wake");
   wake_clear_a: assert property (
      WAKE |-> base_cnt_q == 32'h0 && post_cnt_q == 7'h0)
      else $error("watchdog not cleared on wake");
   run_timeout_a: assert property (
      wdt_to && state_q == SWDW_RUN |=> DEV_RESET && !WAKE)
      else $error("run timeout did not reset");
   timeout_flag_a: assert property (
      wdt_to |=> !status_q[`SWDW_ST_TO])
      else $error("time-out flag not cleared");
   wdt_disabled_a: assert property (
      !watchdog_enable_cfg |-> base_cnt_q == 32'h0 && !wdt_to)
      else $error("disabled watchdog counting");

   sleep_seen_c: cover property (sleep_take ##[1:20] WAKE);
   nop_seen_c: cover property (sleep_nop);
   wdt_wake_c: cover property (state_q == SWDW_SLEEP && wdt_to);
   vector_c: cover property (WAKE_VECTOR);
endmodule

// ==== swdw_core_model.sv ====
/*
 * Behavioural model of the CPU core that issues the sleep and
 * clear-watchdog instruction strobes.
 * Assumes the bench asks for each instruction with a one-cycle request.
 */
`timescale 1ns/1ps

module swdw_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Core clock gate and requests
   input wire logic cpu_clk_en,
   input wire logic want_sleep,
   input wire logic want_clear,
   // Instruction strobes
   output logic sleep_op,
   output logic clear_op
);
   // ==================================================================
   // Strobes, only while the core clock runs
   always_ff @(posedge clk) begin
      if (rst) begin
         sleep_op <= 1'h0;
         clear_op <= 1'h0;
      end else begin
         sleep_op <= want_sleep & cpu_clk_en;
         clear_op <= want_clear & cpu_clk_en;
      end
   end
endmodule

// ==== tb_sleep_wake_and_watchdog.sv ====
/*
 * Self-checking bench of the sleep, wake and watchdog block.
 * Assumes the design files and the core model are compiled first.
 */
`timescale 1ns/1ps
`include "swdw_params.svh"

module tb_sleep_wake_and_watchdog;
   import swdw_pkg::*;
   logic clk, rst, want_sleep, want_clear, sleep_op, clear_op;
   logic ext_pin, ioc_pin, rst_pin_n, cpu_clk_en, io_hold, prefetch;
   logic wake, wake_vec, dev_reset, hit;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   swdw_resp_t bresp, rresp;
   logic [33:0] exp_b[$], exp_r[$];
   int fails, n_compared, n, i, r;

   swdw_top #(.WDT_CYCLES(50)) dut (
      .CLK_SYS(clk), .RST(rst), .SLEEP_OP(sleep_op),
      .CLEAR_WATCHDOG_OP(clear_op), .EXT_INT_PIN(ext_pin),
      .IOC_PIN(ioc_pin), .EXTERNAL_RESET_PIN_N(rst_pin_n),
      .CPU_CLK_EN(cpu_clk_en), .IO_HOLD(io_hold),
      .PREFETCH_NEXT(prefetch), .WAKE(wake), .WAKE_VECTOR(wake_vec),
      .DEV_RESET(dev_reset), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready)
   );

   swdw_core_model core (
      .clk(clk), .rst(rst), .cpu_clk_en(cpu_clk_en),
      .want_sleep(want_sleep), .want_clear(want_clear),
      .sleep_op(sleep_op), .clear_op(clear_op)
   );

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // ==================================================================
   // Compare and closing tasks
   task automatic chk(input string what, input logic [33:0] e,
                      input logic [33:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_bit(input string what, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic done(input string t);
      $display("test %s finished", t);
   endtask

   // ==================================================================
   // Bus master
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input swdw_resp_t rs);
      exp_b.push_back({rs, 32'h0});
      awaddr <= a;
      wdata <= {24'($urandom), d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      exp_r.push_back(e);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      @(posedge clk);
   endtask

   always @(posedge clk) begin
      if (bvalid && bready)
         chk("write response", exp_b.pop_front(), {bresp, 32'h0});
      if (rvalid && rready)
         chk("read data", exp_r.pop_front(), {rresp, rdata});
   end

   // ==================================================================
   // Core requests and event waits
   task automatic op(input logic s);
      want_sleep <= s;
      want_clear <= ~s;
      @(posedge clk);
      want_sleep <= 1'h0;
      want_clear <= 1'h0;
   endtask

   // Event 0 wake, 1 device reset, 2 prefetch
   task automatic wait_ev(input int sel, input int max);
      n = 0;
      hit = 1'h0;
      while (hit !== 1'h1 && n < max) begin
         @(posedge clk);
         n++;
         hit = (sel == 0) ? wake : (sel == 1) ? dev_reset : prefetch;
      end
   endtask

   task automatic sleep_in(input logic taken);
      op(1'h1);
      wait_ev(2, 4);
      chk_bit("prefetch", 1'h1, hit);
      chk_bit("core clock", ~taken, cpu_clk_en);
      chk_bit("io hold", taken, io_hold);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      end_sim;
   end

   // ==================================================================
   // Main sequence
   initial begin
      n = $urandom(49);
      {want_sleep, want_clear, ext_pin, ioc_pin} = 4'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      rst_pin_n = 1'h1;
      rst = 1'h1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      rd(`SWDW_OFF_INTCTL, 34'h0);
      rd(`SWDW_OFF_STATUS, 34'h18);
      rd(`SWDW_OFF_OPTION, 34'hFF);
      rd(`SWDW_OFF_CONFIG, 34'h3FFF);
      wr(`SWDW_OFF_CONFIG, 8'h00, SWDW_OKAY);
      rd(`SWDW_OFF_CONFIG, 34'h3FFF);
      wr(8'h20, 8'h55, SWDW_SLVERR);
      rd(8'h20, {SWDW_SLVERR, 32'h0});
      done("registers");
      wr(`SWDW_OFF_OPTION, 8'h4B, SWDW_OKAY);
      wr(`SWDW_OFF_INTCTL, 8'h10, SWDW_OKAY);
      sleep_in(1'h1);
      rd(`SWDW_OFF_STATUS, 34'h10);
      ext_pin <= 1'h1;
      wait_ev(0, 8);
      chk_bit("pin wake", 1'h1, hit);
      chk_bit("vector", 1'h0, wake_vec);
      chk_bit("awake", 1'h1, cpu_clk_en);
      rd(`SWDW_OFF_INTCTL, 34'h12);
      done("pin wake");
      op(1'h0);
      repeat (2) @(posedge clk);
      sleep_in(1'h0);
      rd(`SWDW_OFF_STATUS, 34'h18);
      done("sleep no-op");
      ext_pin <= 1'h0;
      wr(`SWDW_OFF_INTCTL, 8'h90, SWDW_OKAY);
      sleep_in(1'h1);
      ext_pin <= 1'h1;
      wait_ev(0, 8);
      chk_bit("vector", 1'h1, wake_vec);
      wr(`SWDW_OFF_INTCTL, 8'h08, SWDW_OKAY);
      sleep_in(1'h1);
      ioc_pin <= 1'h1;
      wait_ev(0, 8);
      chk_bit("change wake", 1'h1, hit);
      chk_bit("vector", 1'h0, wake_vec);
      rd(`SWDW_OFF_INTCTL, 34'h09);
      done("interrupt wake");
      wr(`SWDW_OFF_INTCTL, 8'h00, SWDW_OKAY);
      wr(`SWDW_OFF_OPTION, 8'h4A, SWDW_OKAY);
      sleep_in(1'h1);
      ext_pin <= 1'h0;
      ioc_pin <= 1'h0;
      r = $urandom_range(40, 10);
      wait_ev(0, r);
      chk_bit("masked wake", 1'h0, hit);
      ext_pin <= 1'h1;
      wait_ev(0, 240);
      chk_bit("timer wake", 1'h1, hit);
      chk_bit("period", 1'h1, n + r > 190 && n + r < 210);
      rd(`SWDW_OFF_STATUS, 34'h00);
      done("watchdog wake");
      wr(`SWDW_OFF_OPTION, 8'h48, SWDW_OKAY);
      op(1'h0);
      wait_ev(1, 70);
      chk_bit("run timeout", 1'h1, hit);
      chk_bit("period", 1'h1, n > 40);
      rd(`SWDW_OFF_STATUS, 34'h08);
      for (i = 0; i < 6; i++) begin
         op(1'h0);
         wait_ev(1, 30);
         chk_bit("cleared", 1'h0, hit);
      end
      done("watchdog reset");
      sleep_in(1'h1);
      rst_pin_n <= 1'h0;
      wait_ev(1, 8);
      chk_bit("pin reset", 1'h1, hit);
      chk_bit("no wake", 1'h0, wake);
      rst_pin_n <= 1'h1;
      repeat (4) @(posedge clk);
      chk_bit("running", 1'h1, cpu_clk_en);
      chk_bit("io free", 1'h0, io_hold);
      done("pin reset");
      end_sim;
   end
endmodule
